// *** src/pmsc_params.svh ***
// offsets, field positions, reset values and timing counts of the mode/status controller
// assumes inclusion by bare name from the design file only
`ifndef PMSC_PARAMS_SVH
`define PMSC_PARAMS_SVH
// register byte offsets on apb
`define PMSC_OFS_CTRL      8'h00
`define PMSC_OFS_CYCLE_MAX 8'h04
`define PMSC_OFS_STATUS    8'h08
`define PMSC_OFS_FAULT     8'h0c
// control register fields
`define PMSC_CTRL_PG_STOP  0
`define PMSC_CTRL_OVR_REQ  1
// fault register fields
`define PMSC_FLT_ACK       0
`define PMSC_FLT_ADDR      1
`define PMSC_FLT_CYCLE     2
// reset values
`define PMSC_CYCLE_MAX_RST 32'h0002_49f0
`define PMSC_STARTUP_NUM   8'h14
// momentary switch codes: bit1 down, bit0 up
`define PMSC_MSW_MID       2'h0
`define PMSC_MSW_UP        2'h1
`define PMSC_MSW_DOWN      2'h2
// timing: clock rate in MHz, one microsecond in cycles
`define PMSC_CLK_MHZ       250
`define PMSC_US_CYCLES     (`PMSC_CLK_MHZ * 1)
// times in microseconds
`define PMSC_DEBOUNCE_US   10000
`define PMSC_SLOW_HALF_US  500000
`define PMSC_FAST_HALF_US  100000
`endif

// *** src/pmsc_pkg.sv ***
// types of the mode/status controller: states and grouped signals
// assumes nothing of its surroundings
package pmsc_pkg;
    // one-hot operating states
    typedef enum logic [3:0] {
        PMSC_INIT  = 4'h1,
        PMSC_STOP  = 4'h2,
        PMSC_CHECK = 4'h4,
        PMSC_RUN   = 4'h8
    } pmsc_state_t;
    // one input/output access of the program
    typedef struct packed {
        logic       access;
        logic [6:0] addr;
        logic       acked;
    } pmsc_io_req_t;
    // indicator lamps as one group
    typedef struct packed {
        logic run;
        logic stop;
        logic ack_timeout;
        logic address_error;
        logic cycle_overrun;
        logic output_inhibit;
    } pmsc_lamps_t;
endpackage : pmsc_pkg

// *** src/pmsc_ctrl.sv ***
// operating-mode and status-indication controller with apb register access
// assumes event inputs synchronous-domain pins, switch pins asynchronous (synchronised here), one clock pclk
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "pmsc_params.svh"
module pmsc_ctrl #(
    parameter int DEBOUNCE_US = `PMSC_DEBOUNCE_US,
    parameter int SLOW_HALF_US = `PMSC_SLOW_HALF_US,
    parameter int FAST_HALF_US = `PMSC_FAST_HALF_US
) (
    // clock and reset
    input  wire  logic                  pclk,
    input  wire  logic                  presetn,
    // apb slave
    input  wire  logic                  psel,
    input  wire  logic                  penable,
    input  wire  logic                  pwrite,
    input  wire  logic [7:0]            paddr,
    input  wire  logic [31:0]           pwdata,
    output logic       [31:0]           prdata,
    output logic                        pready,
    output logic                        pslverr,
    // operator switches
    input  wire  logic                  mode_run_sw,
    input  wire  logic [1:0]            momentary_switch,
    // system inputs
    input  wire  logic                  battery_ok,
    input  wire  logic                  peer_stop_req,
    input  wire  logic                  int_ovr_req,
    input  wire  logic                  cycle_start,
    input  wire  pmsc_pkg::pmsc_io_req_t io_req,
    input  wire  logic [127:0]          module_detect,
    // lamps
    output pmsc_pkg::pmsc_lamps_t       lamps,
    // program control
    output logic                        outputs_safe,
    output logic                        program_enable,
    output logic                        program_from_start,
    output logic                        restart_startup_routine,
    output logic       [7:0]            startup_routine_num,
    output logic                        erase_all_ram,
    output logic                        clear_image,
    output logic                        stop_others
);
    import pmsc_pkg::*;

    // counts derived from times; long ones in microsecond ticks
    localparam int DEB_TICKS  = DEBOUNCE_US;
    localparam int SLOW_TICKS = SLOW_HALF_US;
    localparam int FAST_TICKS = FAST_HALF_US;
    localparam logic [7:0] US_LAST = 8'(`PMSC_US_CYCLES - 1);

    // elaboration check: counters are 24 bits, rapid must be faster
    if (DEB_TICKS < 1 || SLOW_TICKS >= (1 << 24) || DEB_TICKS >= (1 << 24)
        || FAST_TICKS < 1 || FAST_TICKS >= SLOW_TICKS) begin : g_bad
        $error("pmsc_ctrl: timing parameters out of range");
    end

    // saturating-free count-up end test shared by the debounce and flash tick counters
    function automatic logic cnt_done(input logic [23:0] c, input int lim);
        cnt_done = (c >= 24'(lim - 1));
    endfunction : cnt_done

    // one microsecond enable from a divider
    logic [7:0]  us_cnt;                 // divider count
    logic        us_tick;                // one-cycle enable
    wire         us_wrap = (us_cnt == US_LAST);

    // prescaler: single clock, slower rates as enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_cnt  <= 8'h00;
            us_tick <= 1'b0;
        end else begin
            us_cnt  <= us_wrap ? 8'h00 : us_cnt + 8'h01;
            us_tick <= us_wrap;
        end
    end

    // switch synchroniser stages
    logic [2:0]  sw_meta;                // first stage, read only by second
    logic [2:0]  sw_sync;                // second stage
    logic [2:0]  sw_stable;              // debounced value
    logic [2:0]  sw_last;                // second stage one cycle later
    logic [23:0] deb_cnt;                // time the raw value has held
    wire         sw_differs = (sw_sync != sw_stable);
    wire         sw_moved   = (sw_sync != sw_last);   // any contact change restarts

    // two flops then a hold timer; bounce restarts the timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_meta   <= 3'h0;
            sw_sync   <= 3'h0;
            sw_stable <= 3'h0;
            sw_last   <= 3'h0;
            deb_cnt   <= 24'h00_0000;
        end else begin
            sw_meta <= {mode_run_sw, momentary_switch};
            sw_sync <= sw_meta;
            sw_last <= sw_sync;
            if (!sw_differs || sw_moved) begin
                deb_cnt <= 24'h00_0000;
            end else if (us_tick) begin
                if (cnt_done(deb_cnt, DEB_TICKS)) begin
                    sw_stable <= sw_sync;
                    deb_cnt   <= 24'h00_0000;
                end else begin
                    deb_cnt <= deb_cnt + 24'h00_0001;
                end
            end
        end
    end

    // debounced switch decode
    logic        mode_prev;              // last debounced mode position
    wire         mode_run   = sw_stable[2];
    wire  [1:0]  msw        = sw_stable[1:0];
    wire         to_run     = mode_run & ~mode_prev;
    wire         to_stop    = ~mode_run & mode_prev;
    wire         msw_down   = (msw == `PMSC_MSW_DOWN);
    wire         msw_up     = (msw == `PMSC_MSW_UP);
    wire         msw_mid    = (msw == `PMSC_MSW_MID);

    // flash generators
    logic [23:0] slow_cnt;               // slow half-period count
    logic [23:0] fast_cnt;               // rapid half-period count
    logic        slow_phase;             // slow blink level
    logic        fast_phase;             // rapid blink level

    // blink levels toggled by microsecond ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt   <= 24'h00_0000;
            fast_cnt   <= 24'h00_0000;
            slow_phase <= 1'b0;
            fast_phase <= 1'b0;
        end else if (us_tick) begin
            slow_cnt <= cnt_done(slow_cnt, SLOW_TICKS) ? 24'h00_0000 : slow_cnt + 24'h00_0001;
            fast_cnt <= cnt_done(fast_cnt, FAST_TICKS) ? 24'h00_0000 : fast_cnt + 24'h00_0001;
            if (cnt_done(slow_cnt, SLOW_TICKS)) begin
                slow_phase <= ~slow_phase;
            end
            if (cnt_done(fast_cnt, FAST_TICKS)) begin
                fast_phase <= ~fast_phase;
            end
        end
    end

    // registers and state
    pmsc_state_t state;                  // operating state
    logic        self_stop;              // stop caused by this module
    logic        ovr_pending;            // overall reset awaited
    logic [127:0] present_map;           // modules seen at last reset
    logic [2:0]  fault;                  // sticky ack, addr, cycle
    logic [31:0] cycle_max;              // maximum cycle, microseconds
    logic [31:0] cycle_us;               // elapsed time of this cycle
    logic        pg_stop;                // stop request from software
    logic        sw_ovr_req;             // overall reset from software

    // apb decode
    wire         apb_done = psel & penable & pready;
    wire         apb_wr   = apb_done & pwrite;
    wire         hit_ctrl = (paddr == `PMSC_OFS_CTRL);
    wire         hit_max  = (paddr == `PMSC_OFS_CYCLE_MAX);
    wire         hit_stat = (paddr == `PMSC_OFS_STATUS);
    wire         hit_flt  = (paddr == `PMSC_OFS_FAULT);
    wire         hit_any  = hit_ctrl | hit_max | hit_stat | hit_flt;

    // event decode
    wire         rec_present = present_map[io_req.addr];
    wire         ev_ack   = io_req.access & rec_present & ~io_req.acked;
    wire         ev_addr  = io_req.access & ~rec_present;
    wire         ev_cycle = (state == PMSC_RUN) && (cycle_us > cycle_max);
    wire  [2:0]  fault_set = {ev_cycle, ev_addr, ev_ack};
    wire         in_run   = (state == PMSC_RUN);
    wire         go_ovr   = (state == PMSC_STOP) & to_run & msw_down & battery_ok;
    wire         go_reset = (state == PMSC_STOP) & to_run & msw_up & battery_ok
                            & ~ovr_pending;
    wire         go_rest  = (state == PMSC_STOP) & to_run & msw_mid & battery_ok
                            & ~ovr_pending;
    wire         any_ovr  = int_ovr_req | sw_ovr_req;
    wire         user_stop = to_stop | pg_stop | peer_stop_req;
    wire         fault_stop = |fault_set;

    // next state
    pmsc_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            PMSC_INIT:  next_state = PMSC_STOP;
            PMSC_STOP:  begin
                if (go_reset | go_rest) begin
                    next_state = PMSC_CHECK;
                end
            end
            PMSC_CHECK: begin
                next_state = mode_run ? PMSC_RUN : PMSC_STOP;
            end
            PMSC_RUN:   begin
                if (user_stop | fault_stop | any_ovr) begin
                    next_state = PMSC_STOP;
                end
            end
            default:    next_state = PMSC_INIT;
        endcase
    end

    // state, stop cause and pending overall reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= PMSC_INIT;
            mode_prev   <= 1'b0;
            self_stop   <= 1'b0;
            ovr_pending <= 1'b1;
        end else begin
            state     <= next_state;
            mode_prev <= mode_run;
            if (in_run && fault_stop && !user_stop) begin
                self_stop <= 1'b1;
            end else if (!mode_run || next_state != PMSC_STOP) begin
                self_stop <= 1'b0;
            end
            if (any_ovr) begin
                ovr_pending <= 1'b1;
            end else if (go_ovr) begin
                ovr_pending <= 1'b0;
            end
        end
    end

    // one-cycle actions on switch sequences
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_all_ram           <= 1'b0;
            clear_image             <= 1'b0;
            restart_startup_routine <= 1'b0;
            program_from_start      <= 1'b0;
            present_map             <= '0;
        end else begin
            erase_all_ram           <= go_ovr;
            clear_image             <= go_reset;
            restart_startup_routine <= go_reset;
            program_from_start      <= go_reset;
            if (go_reset) begin
                present_map <= module_detect;
            end
        end
    end

    // cycle timer: restarted by each cycle start, kept at zero outside run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_us <= 32'h0000_0000;
        end else if (!in_run || cycle_start) begin
            cycle_us <= 32'h0000_0000;
        end else if (us_tick && !ev_cycle) begin
            cycle_us <= cycle_us + 32'h0000_0001;
        end
    end

    // sticky faults: hardware set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault <= 3'h0;
        end else if (go_reset || go_ovr) begin
            fault <= fault_set;
        end else begin
            fault <= fault_set | (fault & ~((apb_wr && hit_flt) ? pwdata[2:0] : 3'h0));
        end
    end

    // software control and configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_max  <= `PMSC_CYCLE_MAX_RST;
            pg_stop    <= 1'b0;
            sw_ovr_req <= 1'b0;
        end else begin
            pg_stop    <= apb_wr & hit_ctrl & pwdata[`PMSC_CTRL_PG_STOP];
            sw_ovr_req <= apb_wr & hit_ctrl & pwdata[`PMSC_CTRL_OVR_REQ];
            if (apb_wr && hit_max) begin
                cycle_max <= pwdata;
            end
        end
    end

    // read data selection
    wire  [31:0] status_word = {16'h0000, 2'h0, ovr_pending, self_stop,
                                state, 2'h0, lamps};
    wire  [31:0] next_prdata = hit_max  ? cycle_max :
                               hit_stat ? status_word :
                               hit_flt  ? {29'h0, fault} : 32'h0000_0000;

    // apb: one wait cycle, then registered answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit_any;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // lamp and output decode
    wire         in_stop   = (state == PMSC_STOP);
    wire         stop_lvl  = ovr_pending ? fast_phase :
                             self_stop   ? slow_phase : 1'b1;
    pmsc_lamps_t next_lamps;
    always_comb begin
        next_lamps                = '0;
        next_lamps.run            = in_run & mode_run;
        next_lamps.stop           = in_stop & stop_lvl;
        next_lamps.ack_timeout    = fault[`PMSC_FLT_ACK];
        next_lamps.address_error  = fault[`PMSC_FLT_ADDR];
        next_lamps.cycle_overrun  = fault[`PMSC_FLT_CYCLE];
        next_lamps.output_inhibit = ~in_run;
    end

    // registered outputs toward lamps and program executor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamps               <= '0;
            outputs_safe        <= 1'b1;
            program_enable      <= 1'b0;
            startup_routine_num <= 8'h00;
            stop_others         <= 1'b0;
        end else begin
            lamps               <= next_lamps;
            outputs_safe        <= ~in_run;
            program_enable      <= in_run & mode_run;
            startup_routine_num <= `PMSC_STARTUP_NUM;
            stop_others         <= self_stop;
        end
    end

endmodule : pmsc_ctrl

// *** dv/pmsc_operator.sv ***
// operator model: switch positions and the mode-switch move of one action
// assumes go is a one-cycle request given only while busy is low
`timescale 1ns/100ps
module pmsc_operator #(
    parameter int HOLD = 1200 // covers debounce plus the action itself
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench request
    input  wire logic       go,
    input  wire logic [1:0] pos,
    input  wire logic       run,
    output logic            busy,
    // switch pins
    output logic            mode_run_sw,
    output logic [1:0]      momentary_switch
);
    logic [10:0] cnt;   // step counter, zero when idle
    logic        run_q; // mode position to settle on
    assign busy = (cnt != 11'h000);
    // the mode-switch contact bounces before settling, so a missing debounce shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 11'h000;
            run_q <= 1'b0;
            mode_run_sw <= 1'b0;
            momentary_switch <= 2'h3;
        end else if (go && !busy) begin
            cnt <= 11'h001;
            run_q <= run;
            momentary_switch <= pos;
        end else if (busy) begin
            cnt <= (cnt == HOLD) ? 11'h000 : cnt + 11'h001;
            if (cnt >= 11'h014 && cnt < 11'h01c) mode_run_sw <= cnt[0];
            if (cnt == 11'h01c) mode_run_sw <= run_q;
            if (cnt == HOLD) momentary_switch <= 2'h3; // let go after the move
        end
    end
endmodule : pmsc_operator

// *** dv/pmsc_ctrl_assertions.sv ***
// checker on the lamp and program-control ports of the controller
// assumes one clock pclk and asynchronous active-low presetn
`timescale 1ns/100ps
module pmsc_ctrl_assertions (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // observed outputs
    input wire pmsc_pkg::pmsc_lamps_t lamps,
    input wire logic                  outputs_safe,
    input wire logic                  program_enable,
    input wire logic                  program_from_start,
    input wire logic                  restart_startup_routine,
    input wire logic [7:0]            startup_routine_num,
    input wire logic                  erase_all_ram,
    input wire logic                  clear_image,
    input wire logic                  stop_others
);
    import pmsc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // check state: both lamps dark
    sequence s_dark; !lamps.run && !lamps.stop; endsequence
    // run state shown: run lit, stop and inhibit dark
    sequence s_run; lamps.run && !lamps.stop && !lamps.output_inhibit; endsequence
    a_reset_walk: assert property (program_from_start |=> s_dark ##1 s_run)
        else $error("reset action did not pass check into run");
    a_run_lamps: assert property (lamps.run |-> !lamps.stop && !lamps.output_inhibit)
        else $error("run lamp lit together with stop or inhibit");
    a_enable_lamp: assert property ($rose(program_enable) |-> lamps.run)
        else $error("program enabled without run lamp");
    a_startup_num: assert property (program_from_start |->
        restart_startup_routine && startup_routine_num == 8'h14)
        else $error("startup routine not called with number 20");
    a_clear_pair: assert property (clear_image |-> program_from_start ##1 !clear_image)
        else $error("image clear not a single pulse of a reset");
    a_erase_once: assert property (erase_all_ram |=> !erase_all_ram && !program_enable)
        else $error("ram erase pulse wrong or program started");
    a_erase_steady: assert property (erase_all_ram |-> ##2 (lamps.stop && !lamps.run) [*8])
        else $error("stop lamp not steady after overall reset");
    a_self_dark: assert property (stop_others |-> ##1 !lamps.run)
        else $error("run lamp lit during self stop");
    a_safe_stop: assert property ($rose(outputs_safe) |-> ##[0:2] !program_enable)
        else $error("program still enabled with outputs safe");
endmodule : pmsc_ctrl_assertions
bind pmsc_ctrl pmsc_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .lamps(lamps),
    .outputs_safe(outputs_safe), .program_enable(program_enable),
    .program_from_start(program_from_start), .restart_startup_routine(restart_startup_routine),
    .startup_routine_num(startup_routine_num), .erase_all_ram(erase_all_ram),
    .clear_image(clear_image), .stop_others(stop_others));

// *** dv/tb_plc_mode_status_control.sv ***
// self-checking bench: mode actions, lamps, fault events, apb registers
// assumes short debounce and flash parameters, 250 cycles per microsecond
`timescale 1ns/100ps
module tb_plc_mode_status_control;
    import pmsc_pkg::*;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]   paddr = 0, startup_routine_num, num_seen = 0;
    logic [31:0]  pwdata = 0, prdata, rd;
    logic         pready, pslverr, er, mode_run_sw, battery_ok = 1, peer_stop_req = 0;
    logic         int_ovr_req = 0, cycle_start = 0, go = 0, run = 0, busy;
    logic [1:0]   momentary_switch, pos = 0;
    pmsc_io_req_t io_req = '0;
    logic [127:0] module_detect = '0, map;
    pmsc_lamps_t  lamps;
    logic         outputs_safe, program_enable, program_from_start, restart_startup_routine;
    logic         erase_all_ram, clear_image, stop_others;
    logic [6:0]   a_abs, a_pres;
    int fail_count = 0, check_count = 0, n_clr = 0, n_era = 0, n_fs = 0;
    int b_clr, b_era, b_fs, n, i, k;
    pmsc_ctrl #(.DEBOUNCE_US(2), .SLOW_HALF_US(20), .FAST_HALF_US(5)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_run_sw(mode_run_sw), .momentary_switch(momentary_switch),
        .battery_ok(battery_ok), .peer_stop_req(peer_stop_req), .int_ovr_req(int_ovr_req),
        .cycle_start(cycle_start), .io_req(io_req), .module_detect(module_detect),
        .lamps(lamps), .outputs_safe(outputs_safe), .program_enable(program_enable),
        .program_from_start(program_from_start),
        .restart_startup_routine(restart_startup_routine),
        .startup_routine_num(startup_routine_num), .erase_all_ram(erase_all_ram),
        .clear_image(clear_image), .stop_others(stop_others));
    pmsc_operator #(.HOLD(1200)) u_op (.pclk(pclk), .presetn(presetn), .go(go), .pos(pos),
        .run(run), .busy(busy), .mode_run_sw(mode_run_sw),
        .momentary_switch(momentary_switch));
    initial forever #2 pclk = ~pclk;
    // pulse counters, so short action pulses are never missed
    always @(posedge pclk) begin
        n_clr <= n_clr + clear_image;
        n_era <= n_era + erase_all_ram;
        n_fs <= n_fs + program_from_start;
        if (restart_startup_routine) num_seen <= startup_routine_num;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic tmo(input int c, input int m);
        if (c >= m) begin
            fail_count++;
            finish_test;
        end
    endtask : tmo
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int c;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (pready !== 1 && c < 50);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        tmo(c, 50);
    endtask : apb
    // one operator action through the switch model
    task automatic op(input logic [1:0] p, input logic r);
        b_clr = n_clr;
        b_era = n_era;
        b_fs = n_fs;
        go <= 1;
        pos <= p;
        run <= r;
        @(posedge pclk);
        go <= 0;
        @(posedge pclk);
        for (i = 0; i < 3000 && busy !== 0; i++) @(posedge pclk);
        tmo(i, 3000);
        repeat (4) @(posedge pclk);
    endtask : op
    task automatic rs;
        op(2'h3, 0);
        op(2'h0, 1);
    endtask : rs
    task automatic wstop;
        for (i = 0; i < 4000 && program_enable !== 0; i++) @(posedge pclk);
        tmo(i, 4000);
        repeat (3) @(posedge pclk);
    endtask : wstop
    // cycles between two changes of the stop lamp
    task automatic half(output int m);
        logic v;
        v = lamps.stop;
        for (i = 0; i < 20000 && lamps.stop === v; i++) @(posedge pclk);
        tmo(i, 20000);
        v = lamps.stop;
        for (m = 0; m < 20000 && lamps.stop === v; m++) @(posedge pclk);
        tmo(m, 20000);
    endtask : half
    task automatic io(input logic [6:0] a, input logic ack);
        io_req <= '{1'b1, a, ack};
        @(posedge pclk);
        io_req <= '0;
        @(posedge pclk);
    endtask : io
    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        finish_test;
    end
    initial begin
        void'($urandom(75));
        repeat (20) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        chk("safe", {outputs_safe, lamps.output_inhibit}, 2'h3);
        apb(0, 8'h08, 0);
        chk("status", rd[13:8], 6'h22);
        half(n);
        chk("fast", n >= 1248 && n <= 1252, 1);
        apb(0, 8'h04, 0);
        chk("cmax", rd, 32'h0002_49f0);
        apb(0, 8'h10, 0);
        chk("slverr", er, 1);
        $display("power-up done");
        battery_ok <= 0;
        op(2'h2, 1);
        chk("nobat", n_era - b_era, 0);
        battery_ok <= 1;
        rs;
        apb(0, 8'h08, 0);
        chk("pend", rd[13:8], 6'h22);
        op(2'h3, 0);
        op(2'h2, 1);
        chk("erase", n_era - b_era, 1);
        apb(0, 8'h08, 0);
        chk("nopend", rd[13:8], 6'h02);
        $display("overall reset done");
        map = {$urandom, $urandom, $urandom, $urandom};
        a_abs = $urandom;
        a_pres = a_abs + 7'h01 + 7'($urandom_range(125));
        map[a_abs] = 0;
        map[a_pres] = 1;
        module_detect <= map;
        op(2'h3, 0);
        op(2'h1, 1);
        chk("clr", n_clr - b_clr, 1);
        chk("fromstart", n_fs - b_fs, 1);
        chk("obnum", num_seen, 8'h14);
        chk("run", {lamps, program_enable, outputs_safe}, 8'h82);
        io(a_abs, 1);
        wstop;
        chk("self", {stop_others, lamps.address_error}, 2'h3);
        apb(0, 8'h0c, 0);
        chk("adf", rd[2:0], 3'h2);
        half(n);
        chk("slow", n >= 4998 && n <= 5002, 1);
        op(2'h3, 0);
        n = 0;
        repeat (6000) @(posedge pclk) n += !lamps.stop;
        chk("steady", n, 0);
        apb(1, 8'h0c, 32'h2);
        apb(0, 8'h0c, 0);
        chk("w1c", rd[2:0], 3'h0);
        op(2'h0, 1);
        chk("restart", n_clr - b_clr, 0);
        chk("resume", n_fs - b_fs, 0);
        chk("rerun", lamps.run, 1);
        io(a_pres, 0);
        wstop;
        apb(0, 8'h0c, 0);
        chk("ack", rd[2:0], 3'h1);
        $display("address and acknowledge faults done");
        rs;
        cycle_start <= 1;
        @(posedge pclk);
        cycle_start <= 0;
        apb(1, 8'h04, 32'h3);
        for (k = 0; k < 10; k++) begin
            repeat ($urandom_range(600, 200)) @(posedge pclk);
            cycle_start <= 1;
            @(posedge pclk);
            cycle_start <= 0;
        end
        chk("nozyk", program_enable, 1);
        wstop;
        apb(0, 8'h0c, 0);
        chk("zyk", rd[2:0], 3'h5);
        apb(1, 8'h04, 32'h0002_49f0);
        $display("cycle overrun done");
        rs;
        peer_stop_req <= 1;
        @(posedge pclk);
        peer_stop_req <= 0;
        wstop;
        chk("peer", {stop_others, lamps.stop, lamps.run}, 3'h2);
        rs;
        apb(1, 8'h00, 32'h1);
        wstop;
        chk("pgstop", {stop_others, lamps.stop, lamps.run}, 3'h2);
        rs;
        apb(1, 8'h00, 32'h2);
        wstop;
        apb(0, 8'h08, 0);
        chk("ovrreq", rd[13], 1);
        $display("stop requests done");
        finish_test;
    end
endmodule : tb_plc_mode_status_control
